//--- dec.sv
/* random decoder model; needs the bench clock */
`timescale 1ns/1ps
module dec(input clk,output reg [31:0] o=0);
  integer s=36;
  always @(posedge clk) o<=$random(s);
endmodule

//--- pc_next_address_relative_branch.v
/*
  program counter next-address logic for an 8-bit core: sequential advance by the
  instruction length, absolute branch load and relative branch target selection,
  with a one-cycle flag that marks each loaded branch target.
  assumes the decoder presents one completed instruction per cycle with INSTR_VALID,
  its length in bytes, and branch request, kind, condition and displacement alongside,
  all synchronous to REF_CLK and settled before its rising edge.
  assumes BRANCH_TAKEN is tied high by the decoder for unconditional branches.
  a zero length with INSTR_VALID and no branch leaves the counter unchanged.
*/

`timescale 1ns/1ps
`include "pc_next_defs.vh"

module pc_next_address_relative_branch (
  // clock and reset
  input wire REF_CLK,
  input wire RST,

  // decoder request
  input wire INSTR_VALID,
  input wire [`LEN_WIDTH-1:0] INSTR_LENGTH,
  input wire BRANCH_REQ,
  input wire BRANCH_RELATIVE,
  input wire BRANCH_TAKEN,
  input wire [`PC_WIDTH-1:0] BRANCH_ABS_ADDR,
  input wire [`DISP_WIDTH-1:0] BRANCH_DISPLACEMENT,

  // counter outputs
  output wire [`PC_WIDTH-1:0] PC,
  output wire BRANCHED
);

  // one-hot source codes keep each leg of the counter mux a single decoded bit
  localparam [3:0] SRC_HOLD = 4'h1;
  localparam [3:0] SRC_SEQ = 4'h2;
  localparam [3:0] SRC_REL = 4'h4;
  localparam [3:0] SRC_ABS = 4'h8;

  // registered state and its next values
  reg [`PC_WIDTH-1:0] pc_ff;
  reg branched_ff;
  reg [`PC_WIDTH-1:0] nxt_pc;
  reg nxt_branched;
  reg [3:0] src_sel;

  // candidate next addresses
  wire [`PC_WIDTH-1:0] len_word;
  wire [`PC_WIDTH-1:0] follow_addr;
  wire [`PC_WIDTH-1:0] rel_target;
  wire [`PC_WIDTH-1:0] abs_target;
  wire branch_go;

  // extend a byte count to the counter width
  function [`PC_WIDTH-1:0] len_ext;
    input [`LEN_WIDTH-1:0] len;
    begin
      len_ext = {{(`PC_WIDTH-`LEN_WIDTH){1'b0}}, len};
    end
  endfunction

  // modulo add on the counter width: a carry out of bit 15 is lost on purpose
  function [`PC_WIDTH-1:0] wrap_add;
    input [`PC_WIDTH-1:0] base;
    input [`PC_WIDTH-1:0] step;
    begin
      wrap_add = base + step;
    end
  endfunction

  // a branch loads only with a completed instruction and a met condition
  function branch_fires;
    input valid;
    input req;
    input taken;
    begin
      branch_fires = valid & req & taken;
    end
  endfunction

  // truth table of the source choice; exactly one code bit is ever set
  function [3:0] pick_source;
    input valid;
    input fires;
    input relative;
    begin
      case ({valid, fires, relative})
        // no completed instruction: hold
        3'h0: begin
          pick_source = SRC_HOLD;
        end
        3'h1: begin
          pick_source = SRC_HOLD;
        end
        3'h2: begin
          pick_source = SRC_HOLD;
        end
        3'h3: begin
          pick_source = SRC_HOLD;
        end
        // no branch, or its condition not met: fall through
        3'h4: begin
          pick_source = SRC_SEQ;
        end
        3'h5: begin
          pick_source = SRC_SEQ;
        end
        // taken branch: absolute or relative target
        3'h6: begin
          pick_source = SRC_ABS;
        end
        3'h7: begin
          pick_source = SRC_REL;
        end
        default: begin
          pick_source = SRC_HOLD;
        end
      endcase
    end
  endfunction

  // a loaded branch target is flagged for one cycle
  function is_branch_source;
    input [3:0] src;
    begin
      case (src)
        SRC_HOLD: begin
          is_branch_source = 1'b0;
        end
        SRC_SEQ: begin
          is_branch_source = 1'b0;
        end
        SRC_REL: begin
          is_branch_source = 1'b1;
        end
        SRC_ABS: begin
          is_branch_source = 1'b1;
        end
        default: begin
          is_branch_source = 1'b0;
        end
      endcase
    end
  endfunction

  assign len_word = len_ext(INSTR_LENGTH);

  // the sequential address doubles as the base for relative targets
  assign follow_addr = wrap_add(pc_ff, len_word);

  assign abs_target = BRANCH_ABS_ADDR;

  assign branch_go = branch_fires(INSTR_VALID, BRANCH_REQ, BRANCH_TAKEN);

  rel_target_adder u_rel (
    .follow_addr(follow_addr),
    .branch_displacement(BRANCH_DISPLACEMENT),
    .target_addr(rel_target)
  );

  // a conditional branch not taken falls through sequentially
  always @* begin
    src_sel = pick_source(INSTR_VALID, branch_go, BRANCH_RELATIVE);
  end

  // only one source is live per cycle
  always @* begin
    nxt_pc = pc_ff;
    case (src_sel)
      SRC_HOLD: begin
        nxt_pc = pc_ff;
      end
      SRC_SEQ: begin
        nxt_pc = follow_addr;
      end
      SRC_REL: begin
        nxt_pc = rel_target;
      end
      SRC_ABS: begin
        nxt_pc = abs_target;
      end
      default: begin
        // an illegal code holds rather than jumping anywhere
        nxt_pc = pc_ff;
      end
    endcase
  end

  // the flag follows the source, not the address, so a branch to itself still shows
  always @* begin
    nxt_branched = is_branch_source(src_sel);
  end

  // the counter and the flag reset together with the core
  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      pc_ff <= `PC_RESET_VALUE;
    end else begin
      pc_ff <= nxt_pc;
    end
  end

  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      branched_ff <= 1'b0;
    end else begin
      branched_ff <= nxt_branched;
    end
  end

  assign PC = pc_ff;
  assign BRANCHED = branched_ff;
endmodule

//--- pc_next_defs.vh
/*
  constants for the program counter next-address logic.
  assumes inclusion by bare name from the design files.
*/
`ifndef PC_NEXT_DEFS_VH
`define PC_NEXT_DEFS_VH
`define PC_WIDTH 16
`define PC_RESET_VALUE 16'h0000
`define DISP_WIDTH 8
`define DISP_SIGN_BIT 7
`define LEN_WIDTH 3
`endif

//--- pcc_assertions.sv
/*
  concurrent checks on the program counter next-address block, seen from its ports.
  assumes binding into that block; expected addresses are rebuilt from the inputs
  and the previous counter value, at 16 bits so a wrap past the top is expected.
*/
`timescale 1ns/1ps
module pc_next_checker (
  // clock and reset
  input wire REF_CLK,
  input wire RST,
  // decoder request
  input wire INSTR_VALID,
  input wire [2:0] INSTR_LENGTH,
  input wire BRANCH_REQ,
  input wire BRANCH_RELATIVE,
  input wire BRANCH_TAKEN,
  input wire [15:0] BRANCH_ABS_ADDR,
  input wire [7:0] BRANCH_DISPLACEMENT,
  // counter outputs
  input wire [15:0] PC,
  input wire BRANCHED
);
  wire branch_now;
  wire [15:0] seq_addr;
  wire [15:0] rel_addr;
  assign branch_now = INSTR_VALID & BRANCH_REQ & BRANCH_TAKEN;
  assign seq_addr = PC + {13'h0, INSTR_LENGTH};
  assign rel_addr = seq_addr + {{8{BRANCH_DISPLACEMENT[7]}}, BRANCH_DISPLACEMENT};

  // the sampled reset term skips the edge that releases reset, where the design is still held
  property p_a;
    @(posedge REF_CLK) disable iff (RST)
      !RST && INSTR_VALID |=> BRANCHED == $past(branch_now) && (BRANCHED || PC == $past(seq_addr));
  endproperty
  a_a: assert property (p_a) else $error("counter or flag wrong");

  property p_hold;
    @(posedge REF_CLK) disable iff (RST)
      !RST && !INSTR_VALID |=> PC == $past(PC) && !BRANCHED;
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved while idle");

  property p_seq;
    @(posedge REF_CLK) disable iff (RST)
      !RST && INSTR_VALID && !branch_now |=> PC == $past(seq_addr) && !BRANCHED;
  endproperty
  a_seq: assert property (p_seq) else $error("sequential advance wrong");

  property p_abs;
    @(posedge REF_CLK) disable iff (RST)
      !RST && branch_now && !BRANCH_RELATIVE |=> PC == $past(BRANCH_ABS_ADDR) && BRANCHED;
  endproperty
  a_abs: assert property (p_abs) else $error("absolute target not loaded");

  property p_rel;
    @(posedge REF_CLK) disable iff (RST)
      !RST && branch_now && BRANCH_RELATIVE |=> PC == $past(rel_addr) && BRANCHED;
  endproperty
  a_rel: assert property (p_rel) else $error("relative target wrong");

  property p_fall;
    @(posedge REF_CLK) disable iff (RST)
      !RST && INSTR_VALID && BRANCH_REQ && !BRANCH_TAKEN |=> PC == $past(seq_addr) && !BRANCHED;
  endproperty
  a_fall: assert property (p_fall) else $error("untaken branch loaded a target");

  property p_flag_once;
    @(posedge REF_CLK) disable iff (RST)
      !RST && BRANCHED && !branch_now |=> !BRANCHED;
  endproperty
  a_flag_once: assert property (p_flag_once) else $error("branch flag stood too long");
endmodule
bind pc_next_address_relative_branch pc_next_checker u_pc_next_checker (
  .REF_CLK(REF_CLK),
  .RST(RST),
  .INSTR_VALID(INSTR_VALID),
  .INSTR_LENGTH(INSTR_LENGTH),
  .BRANCH_REQ(BRANCH_REQ),
  .BRANCH_RELATIVE(BRANCH_RELATIVE),
  .BRANCH_TAKEN(BRANCH_TAKEN),
  .BRANCH_ABS_ADDR(BRANCH_ABS_ADDR),
  .BRANCH_DISPLACEMENT(BRANCH_DISPLACEMENT),
  .PC(PC),
  .BRANCHED(BRANCHED)
);

//--- rel_target_adder.v
/*
  relative branch target adder: follow-on address plus sign-extended displacement.
  assumes the caller supplies the start address of the following instruction.
*/
`timescale 1ns/1ps
`include "pc_next_defs.vh"
module rel_target_adder (
  // operands
  input wire [`PC_WIDTH-1:0] follow_addr,
  input wire [`DISP_WIDTH-1:0] branch_displacement,
  // result
  output wire [`PC_WIDTH-1:0] target_addr
);
  // upper bits copy the sign bit
  wire [`PC_WIDTH-1:0] disp_ext;
  assign disp_ext = {{(`PC_WIDTH-`DISP_WIDTH){branch_displacement[`DISP_SIGN_BIT]}},
                     branch_displacement};
  // carry out of bit 15 drops by the sum width
  assign target_addr = follow_addr + disp_ext;
endmodule

//--- tb_top.sv
/* self-checking bench; needs dec */
`timescale 1ns/1ps
module tb_top;
  reg c=0,rst=1;
  reg [15:0] e=0;
  reg [16:0] q[$];
  integer n_errors=0,compares=0,n=0;
  wire [31:0] o;
  wire [16:0] w;
  always #2 c=~c;
  dec u_dec(.clk(c),.o(o));
  pc_next_address_relative_branch u_pc_next_address_relative_branch(.REF_CLK(c),.RST(rst),
    .INSTR_VALID(o[30]),.INSTR_LENGTH(o[29:27]),.BRANCH_REQ(o[26]),.BRANCH_RELATIVE(o[25]),
    .BRANCH_TAKEN(o[24]),.BRANCH_DISPLACEMENT(o[23:16]),.BRANCH_ABS_ADDR(o[15:0]),.PC(w[15:0]),
    .BRANCHED(w[16]));
  task cmp(input [16:0] s,x);
    compares=compares+1;
    if(s!==x) begin n_errors=n_errors+1; $display("wrong value %0t %h %h",$time,s,x); end
  endtask
  task wrap_up;
    if(n_errors==0&&compares>0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(negedge c) if(q.size()) cmp(w,q.pop_front());
  always @(posedge c) begin
    n<=n+1;
    if(n==5) rst<=0;
    if(compares==2000) wrap_up;
    else if(n==3000) begin n_errors=n_errors+1; wrap_up; end
    else if(!rst) begin
      if(o[30]) e=o[26]&o[24]?(o[25]?e+o[29:27]+{{8{o[23]}},o[23:16]}:o[15:0]):e+o[29:27];
      q.push_back({o[30]&o[26]&o[24],e});
    end
  end
endmodule
